//--- pll_pd_pkg.sv
// Purpose: shared constants and types for the PLL charge-pump output block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: all offsets are byte addresses
package pll_pd_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] DIVN_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] REFDIV_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h0C;
  // control register fields
  localparam int CTRL_BAND_LSB = 0;
  localparam int CTRL_FM_BIT = 4;
  localparam int CTRL_SBEN_BIT = 8;
  localparam int CTRL_CSTOP_BIT = 9;
  localparam int CTRL_PSTOP_BIT = 10;
  localparam int CTRL_DZ_LSB = 12;
  localparam logic [31:0] CTRL_MASK = 32'h0000_F713;
  localparam logic [31:0] CTRL_RST = 32'h0000_0400;
  localparam logic [CNT_W-1:0] DIVN_RST = 16'h0001;
  localparam logic [CNT_W-1:0] REFDIV_RST = 16'h0001;
  // status register fields
  localparam int STAT_UP_BIT = 0;
  localparam int STAT_DOWN_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_HIZ_BIT = 3;
  localparam int STAT_BAND_LSB = 4;
  localparam int STAT_FM_BIT = 6;
  // sub-pump modes on dead-zone bits b3,b2
  localparam logic [1:0] DZ_OFF = 2'h0;
  localparam logic [1:0] DZ_MAIN = 2'h1;
  localparam logic [1:0] DZ_INV = 2'h2;
  // nominal crystal on the crystal pins
  localparam int XTAL_FREQ_KHZ = 4500;
  typedef enum logic [1:0] {PUMP_HIZ, PUMP_UP, PUMP_DOWN} pump_t;
endpackage

//--- pfd_if.sv
// Purpose: carries edge pulses and pump requests between control and detector
// Assumes: single pclk domain
// Notes: freeze clears the detector
`timescale 1ns/1ps
interface pfd_if;
  logic div_edge;
  logic ref_edge;
  logic freeze;
  logic up;
  logic down;
  modport det (input div_edge, input ref_edge, input freeze, output up, output down);
  modport ctl (output div_edge, output ref_edge, output freeze, input up, input down);
endinterface

//--- phase_freq_det.sv
// Purpose: phase/frequency detector between divided oscillator and reference
// Assumes: edges are one-cycle pulses in the pclk domain
// Notes: up means divided oscillator leads, down means it lags
`timescale 1ns/1ps
module phase_freq_det (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // detector side
  pfd_if.det pd
);
  logic up_r;
  logic up_nxt;
  logic down_r;
  logic down_nxt;

  always_comb
  begin
    up_nxt = up_r | pd.div_edge;
    down_nxt = down_r | pd.ref_edge;
    // both seen: frequencies match, pumps release
    if (up_nxt && down_nxt)
    begin
      up_nxt = 1'b0;
      down_nxt = 1'b0;
    end
    if (pd.freeze)
    begin
      up_nxt = 1'b0;
      down_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_r <= 1'b0;
      down_r <= 1'b0;
    end
    else
    begin
      up_r <= up_nxt;
      down_r <= down_nxt;
    end
  end

  assign pd.up = up_r;
  assign pd.down = down_r;

  freeze_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    pd.freeze |=> !up_r && !down_r)
    else $error("detector not cleared by freeze");
  never_both_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(up_r && down_r))
    else $error("detector up and down together");
endmodule

//--- pll_phase_detector_outputs.sv
// Purpose: charge-pump outputs, oscillator select and APB registers of a tuning PLL
// Assumes: all pins synchronous to pclk; crystal_input far slower than pclk
// Notes: tristate pins are value plus enable, enable high while driving
//
// Contract
// - main pumps high above, low below reference
// - main pumps high impedance when frequencies match
// - main pumps released on standby request
// - main pumps released in stop and reset
// - fm input selected, band bits ignored
// - fm input disabled on standby request
// - fm input disabled in stop and reset
// - am input selected, low bits set band
// - dead-zone b3,b2 steer the fast-lock pump
// - inverted pump: low above, high below
// - inverted pump released when frequencies match
// - inverted pump released on standby request
// - inverted pump released in stop and reset
// - reference timing derived from crystal input
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module pll_phase_detector_outputs (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal
  input wire logic crystal_input,
  output logic crystal_output,
  // oscillator inputs
  input wire logic fm_osc_input,
  input wire logic am_osc_input,
  // standby request, active low
  input wire logic standby_req_n,
  // charge pumps
  output logic main_pump_out_a,
  output logic main_pump_out_a_oe,
  output logic main_pump_out_b,
  output logic main_pump_out_b_oe,
  output logic inverted_pump_out,
  output logic inverted_pump_out_oe,
  output logic fast_lock_pump_out,
  output logic fast_lock_pump_out_oe
);
  pfd_if pd ();

  // registers
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [15:0] divn_r, divn_nxt;
  logic [15:0] refdiv_r, refdiv_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] status;
  logic setup, wr_acc, mapped;

  // control fields
  logic fm_sel, standby_hold, hiz;
  logic [1:0] band, dz_mode;

  // divider state
  logic por_done_r, xtal_d_r, osc_d_r, osc_in;
  logic [15:0] div_cnt_r, div_cnt_nxt;
  logic [15:0] ref_cnt_r, ref_cnt_nxt;
  logic div_pulse_r, div_pulse_nxt;
  logic ref_pulse_r, ref_pulse_nxt;

  // pump outputs
  pll_pd_pkg::pump_t pump;
  logic [7:0] pins_r, pins_nxt;

  assign fm_sel = ctrl_r[pll_pd_pkg::CTRL_FM_BIT];
  assign band = ctrl_r[pll_pd_pkg::CTRL_BAND_LSB +: 2];
  assign dz_mode = ctrl_r[pll_pd_pkg::CTRL_DZ_LSB + 2 +: 2];
  assign standby_hold = !standby_req_n && ctrl_r[pll_pd_pkg::CTRL_SBEN_BIT];
  // any release condition wins over the comparison
  assign hiz = standby_hold || ctrl_r[pll_pd_pkg::CTRL_CSTOP_BIT]
    || ctrl_r[pll_pd_pkg::CTRL_PSTOP_BIT] || !por_done_r;

  // fm path gated off under any release condition; am path carries band
  always_comb
  begin
    if (fm_sel)
      osc_in = fm_osc_input && !hiz;
    else
      osc_in = am_osc_input;
  end

  // divide-by-N of the selected oscillator and crystal reference divider
  always_comb
  begin
    div_cnt_nxt = div_cnt_r;
    div_pulse_nxt = 1'b0;
    ref_cnt_nxt = ref_cnt_r;
    ref_pulse_nxt = 1'b0;
    if (osc_in && !osc_d_r)
    begin
      if (div_cnt_r >= divn_r)
      begin
        div_cnt_nxt = 16'h0001;
        div_pulse_nxt = 1'b1;
      end
      else
        div_cnt_nxt = div_cnt_r + 16'h0001;
    end
    if (crystal_input && !xtal_d_r)
    begin
      if (ref_cnt_r >= refdiv_r)
      begin
        ref_cnt_nxt = 16'h0001;
        ref_pulse_nxt = 1'b1;
      end
      else
        ref_cnt_nxt = ref_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_done_r <= 1'b0;
      xtal_d_r <= 1'b0;
      osc_d_r <= 1'b0;
      div_cnt_r <= 16'h0001;
      ref_cnt_r <= 16'h0001;
      div_pulse_r <= 1'b0;
      ref_pulse_r <= 1'b0;
    end
    else
    begin
      por_done_r <= 1'b1;
      xtal_d_r <= crystal_input;
      osc_d_r <= osc_in;
      div_cnt_r <= div_cnt_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      div_pulse_r <= div_pulse_nxt;
      ref_pulse_r <= ref_pulse_nxt;
    end
  end

  assign pd.div_edge = div_pulse_r;
  assign pd.ref_edge = ref_pulse_r;
  assign pd.freeze = hiz;

  phase_freq_det u_det (
    .pclk(pclk),
    .presetn(presetn),
    .pd(pd.det)
  );

  always_comb
  begin
    if (hiz)
      pump = pll_pd_pkg::PUMP_HIZ;
    else if (pd.up)
      pump = pll_pd_pkg::PUMP_UP;
    else if (pd.down)
      pump = pll_pd_pkg::PUMP_DOWN;
    else
      pump = pll_pd_pkg::PUMP_HIZ;
  end

  // pins_r: {a, a_oe, b, b_oe, inv, inv_oe, fast, fast_oe}
  always_comb
  begin
    pins_nxt = 8'h00;
    unique case (pump)
      pll_pd_pkg::PUMP_UP: pins_nxt[7:2] = 6'h3D;
      pll_pd_pkg::PUMP_DOWN: pins_nxt[7:2] = 6'h17;
      pll_pd_pkg::PUMP_HIZ: pins_nxt[7:2] = 6'h00;
    endcase
    if (pump != pll_pd_pkg::PUMP_HIZ)
    begin
      if (dz_mode == pll_pd_pkg::DZ_MAIN)
      begin
        pins_nxt[1:0] = {pins_nxt[7], 1'b1};
      end
      else if (dz_mode == pll_pd_pkg::DZ_INV)
      begin
        pins_nxt[1:0] = {pins_nxt[3], 1'b1};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_r <= 8'h00;
      crystal_output <= 1'b0;
    end
    else
    begin
      pins_r <= pins_nxt;
      crystal_output <= !crystal_input;
    end
  end

  assign main_pump_out_a = pins_r[7];
  assign main_pump_out_a_oe = pins_r[6];
  assign main_pump_out_b = pins_r[5];
  assign main_pump_out_b_oe = pins_r[4];
  assign inverted_pump_out = pins_r[3];
  assign inverted_pump_out_oe = pins_r[2];
  assign fast_lock_pump_out = pins_r[1];
  assign fast_lock_pump_out_oe = pins_r[0];

  // apb slave, answers in the first access cycle
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;
  assign mapped = paddr == pll_pd_pkg::CTRL_OFF || paddr == pll_pd_pkg::DIVN_OFF
    || paddr == pll_pd_pkg::REFDIV_OFF || paddr == pll_pd_pkg::STAT_OFF;

  always_comb
  begin
    status = 32'h0000_0000;
    status[pll_pd_pkg::STAT_UP_BIT] = pd.up;
    status[pll_pd_pkg::STAT_DOWN_BIT] = pd.down;
    status[pll_pd_pkg::STAT_LOCK_BIT] = !pd.up && !pd.down && !hiz;
    status[pll_pd_pkg::STAT_HIZ_BIT] = hiz;
    // band only meaningful on the am path
    status[pll_pd_pkg::STAT_BAND_LSB +: 2] = fm_sel ? 2'h0 : band;
    status[pll_pd_pkg::STAT_FM_BIT] = fm_sel;
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    divn_nxt = divn_r;
    refdiv_nxt = refdiv_r;
    prdata_nxt = prdata_r;
    pready_nxt = setup;
    pslverr_nxt = setup && !mapped;
    if (setup)
    begin
      unique case (paddr)
        pll_pd_pkg::CTRL_OFF: prdata_nxt = ctrl_r;
        pll_pd_pkg::DIVN_OFF: prdata_nxt = {16'h0000, divn_r};
        pll_pd_pkg::REFDIV_OFF: prdata_nxt = {16'h0000, refdiv_r};
        pll_pd_pkg::STAT_OFF: prdata_nxt = status;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_acc)
    begin
      unique case (paddr)
        pll_pd_pkg::CTRL_OFF: ctrl_nxt = pwdata & pll_pd_pkg::CTRL_MASK;
        pll_pd_pkg::DIVN_OFF: divn_nxt = pwdata[15:0];
        pll_pd_pkg::REFDIV_OFF: refdiv_nxt = pwdata[15:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= pll_pd_pkg::CTRL_RST;
      divn_r <= pll_pd_pkg::DIVN_RST;
      refdiv_r <= pll_pd_pkg::REFDIV_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      divn_r <= divn_nxt;
      refdiv_r <= refdiv_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_access_s;
    psel && penable;
  endsequence
  sequence divn_write_s;
    psel && penable && pready && pwrite && paddr == pll_pd_pkg::DIVN_OFF;
  endsequence

  apb_ready_a: assert property (apb_setup_s ##1 apb_access_s |-> pready)
    else $error("no ready in first access cycle");
  divn_update_a: assert property (divn_write_s |=> divn_r == $past(pwdata[15:0]))
    else $error("divider write lost");
  main_up_a: assert property (!hiz && pd.up |=>
    main_pump_out_a && main_pump_out_a_oe && main_pump_out_b && main_pump_out_b_oe)
    else $error("main pumps not high while leading");
  main_match_a: assert property (!pd.up && !pd.down |=>
    !main_pump_out_a_oe && !main_pump_out_b_oe)
    else $error("main pumps driven at match");
  standby_rel_a: assert property (standby_hold |=>
    !main_pump_out_a_oe && !main_pump_out_b_oe)
    else $error("main pumps driven in standby");
  stop_rel_a: assert property (ctrl_r[pll_pd_pkg::CTRL_CSTOP_BIT]
    || ctrl_r[pll_pd_pkg::CTRL_PSTOP_BIT] |=> !main_pump_out_a_oe && !main_pump_out_b_oe)
    else $error("main pumps driven while stopped");
  fm_gate_a: assert property (fm_sel && hiz |-> !osc_in)
    else $error("fm input passed while released");
  inv_down_a: assert property (!hiz && pd.down |=>
    inverted_pump_out && inverted_pump_out_oe && !main_pump_out_a)
    else $error("inverted pump polarity wrong");
  inv_release_a: assert property (hiz || (!pd.up && !pd.down) |=>
    !inverted_pump_out_oe && !fast_lock_pump_out_oe)
    else $error("inverted or fast pump driven when released");
  fast_main_a: assert property (dz_mode == pll_pd_pkg::DZ_MAIN && !hiz && pd.up |=>
    fast_lock_pump_out && fast_lock_pump_out_oe)
    else $error("fast-lock pump not following main");
endmodule

//--- vco_model.sv
// Purpose: far-side local oscillator model feeding an oscillator pin
// Assumes: square wave, half period set by the bench in pclk cycles
// Notes: a half period of zero holds the pin still
`timescale 1ns/1ps
module vco_model (
  // clock
  input wire logic pclk,
  // tuning
  input wire logic [7:0] half_per,
  // oscillator
  output logic osc
);
  logic [7:0] cnt_r;
  initial
  begin
    osc = 1'b0;
    cnt_r = 8'h00;
  end
  // stands in for the loop filter plus vco; tuning is set by the bench
  always @(posedge pclk)
  begin
    if (half_per != 8'h00 && cnt_r + 8'h01 >= half_per)
    begin
      cnt_r <= 8'h00;
      osc <= ~osc;
    end
    else
      cnt_r <= cnt_r + 8'h01;
  end
endmodule

//--- test_pll_phase_detector_outputs.sv
// Purpose: self-checking bench for the charge-pump output block
// Assumes: crystal period 8 pclk, fm period 4, am period 16, dividers 1
// Notes: direction judged by majority, pulses alternate with each edge
`timescale 1ns/1ps
module test_pll_phase_detector_outputs;
  logic pclk, presetn, psel, penable, pwrite, xtal_in, sby_n, fm, am, err;
  logic pready, pslverr, xtal_out, pa, pa_oe, pb, pb_oe, pi, pi_oe, pf, pf_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] xc;
  int failures, cmp_count;
  pll_phase_detector_outputs u_pll_phase_detector_outputs (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_input(xtal_in), .crystal_output(xtal_out),
    .fm_osc_input(fm), .am_osc_input(am), .standby_req_n(sby_n),
    .main_pump_out_a(pa), .main_pump_out_a_oe(pa_oe), .main_pump_out_b(pb),
    .main_pump_out_b_oe(pb_oe), .inverted_pump_out(pi),
    .inverted_pump_out_oe(pi_oe), .fast_lock_pump_out(pf),
    .fast_lock_pump_out_oe(pf_oe));
  vco_model u_vco_fm (.pclk(pclk), .half_per(8'h02), .osc(fm));
  vco_model u_vco_am (.pclk(pclk), .half_per(8'h08), .osc(am));
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    xc <= xc + 2'h1;
    if (xc == 2'h3)
      xtal_in <= ~xtal_in;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one transfer; entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // judges 200 cycles of pump pins; also the crystal inverter
  task automatic measure(input logic exp_up, input logic [1:0] dz);
    int up, dn, bad, xbad;
    logic px;
    up = 0;
    dn = 0;
    bad = 0;
    xbad = 0;
    px = xtal_in;
    repeat (200)
    begin
      @(posedge pclk);
      if (xtal_out !== ~px)
        xbad++;
      px = xtal_in;
      if (pa_oe === 1'b1)
      begin
        if (pa === 1'b1)
          up++;
        else
          dn++;
        if (pb !== pa || pi !== ~pa || pb_oe !== 1'b1 || pi_oe !== 1'b1)
          bad++;
        if ((dz == 2'h1 && pf !== pa) || (dz == 2'h2 && pf !== pi))
          bad++;
        // fast pump driven only in the two follow modes
        if (pf_oe !== (dz[1] ^ dz[0]))
          bad++;
      end
    end
    chk("pump activity", 32'(up + dn > 0), 1);
    chk("crystal out", xbad, 0);
    chk("pump coherence", bad, 0);
    chk("pump direction", 32'(up > dn), 32'(exp_up));
  endtask
  task automatic released(input string what);
    repeat (2) @(posedge pclk);
    chk(what, {pa_oe, pb_oe, pi_oe, pf_oe}, 0);
  endtask
  task automatic t_reset;
    chk("oe after reset", {pa_oe, pb_oe, pi_oe, pf_oe}, 0);
    apb(1'b0, 8'h00, 0);
    chk("ctrl reset", rd, pll_pd_pkg::CTRL_RST);
    apb(1'b0, 8'h04, 0);
    chk("divn reset", rd, 1);
    apb(1'b0, 8'h10, 0);
    chk("unmapped err", 32'(err), 1);
    chk("unmapped data", rd, 0);
  endtask
  task automatic t_fm;
    // band bits set on purpose: they must not leak into status
    apb(1'b1, 8'h00, 32'h0000_4013);
    apb(1'b0, 8'h0C, 0);
    chk("fm status", rd[6:4], 3'h4);
    measure(1'b1, 2'h1);
  endtask
  task automatic t_am;
    apb(1'b1, 8'h00, 32'h0000_8002);
    apb(1'b0, 8'h0C, 0);
    chk("am status", rd[6:4], 3'h2);
    measure(1'b0, 2'h2);
  endtask
  task automatic t_standby;
    sby_n <= 1'b0;
    measure(1'b0, 2'h2);
    apb(1'b1, 8'h00, 32'h0000_8112);
    released("standby oe");
    apb(1'b0, 8'h0C, 0);
    chk("standby status", {rd[3], rd[1:0]}, 3'h4);
    sby_n <= 1'b1;
    measure(1'b1, 2'h2);
  endtask
  task automatic t_stops;
    apb(1'b1, 8'h00, 32'h0000_8212);
    released("clock stop oe");
    apb(1'b1, 8'h00, 32'h0000_8412);
    released("pll stop oe");
    apb(1'b1, 8'h00, 32'h0000_8012);
    // both fast-pump off codes: main pumps still work
    apb(1'b1, 8'h00, 32'h0000_C012);
    measure(1'b1, 2'h3);
    apb(1'b1, 8'h00, 32'h0000_0012);
    measure(1'b1, 2'h0);
  endtask
  task automatic t_reset_mid;
    presetn <= 1'b0;
    released("reset oe");
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 0);
    chk("ctrl after reset", rd, pll_pd_pkg::CTRL_RST);
    released("pll stop after reset");
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    xtal_in = 1'b0;
    xc = 2'h0;
    sby_n = 1'b1;
    failures = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fm();
    t_am();
    t_standby();
    t_stops();
    t_reset_mid();
    end_of_test();
  end
endmodule
